// ===== hdl/csrm_top.sv
// Purpose: Clock status readback registers and monitor pin selector
// Assumes: Status inputs and register strobes are synchronous to clk_sys
// Notes:   Readback reflects live status; data appears one cycle later
module csrm_top (
  // Clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       nrst,
  // Register port
  input  wire logic [csrm_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  input  wire logic [csrm_pkg::DATA_W-1:0] reg_wdata,
  output logic      [csrm_pkg::DATA_W-1:0] reg_rdata,
  output logic                            reg_rvalid,
  // Clock presence levels
  input  wire logic                       first_reference_ok,
  input  wire logic                       second_reference_ok,
  input  wire logic                       test_reference_ok,
  input  wire logic                       osc_clock_ok,
  input  wire logic                       cleanup_loop_fb_ok,
  input  wire logic                       synth_loop_ref_ok,
  // Loop and selection status
  input  wire logic                       cleanup_loop_locked,
  input  wire logic                       synth_loop_locked,
  input  wire logic                       holdover_active,
  input  wire logic                       auto_second_reference,
  input  wire logic                       osc_cal_busy,
  // Cleanup loop signals for halved monitoring
  input  wire logic                       cleanup_loop_fb_sig,
  input  wire logic                       cleanup_loop_pfd_dn,
  input  wire logic                       cleanup_loop_ref_sig,
  input  wire logic                       cleanup_loop_pfd_up,
  // Status monitor pin
  output logic                            monitor_pin
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [csrm_pkg::SEL_W-1:0]  sel_ff;
  logic [csrm_pkg::SEL_W-1:0]  nxt_sel;
  logic [csrm_pkg::DATA_W-1:0] rdata_ff;
  logic [csrm_pkg::DATA_W-1:0] nxt_rdata;
  logic                        rvalid_ff;
  logic                        nxt_rvalid;
  logic                        pin_ff;
  logic                        nxt_pin;
  logic [csrm_pkg::DATA_W-1:0] rb0_live;
  logic [csrm_pkg::DATA_W-1:0] rb1_live;
  logic [csrm_pkg::HALF_CH-1:0] half_src;
  logic [csrm_pkg::HALF_CH-1:0] half_sig;
  logic                        refs_lost;

  // ----------------------------------------------------------------
  // Live readback images
  // ----------------------------------------------------------------
  // Built combinationally so a read returns status at read time
  always_comb begin
    rb0_live = '0;
    rb1_live = '0;
    rb0_live[csrm_pkg::RB0_SYNTH_REF_BIT]  = synth_loop_ref_ok;
    rb0_live[csrm_pkg::RB0_CLEAN_FB_BIT]   = cleanup_loop_fb_ok;
    rb0_live[csrm_pkg::RB0_OSC_BIT]        = osc_clock_ok;
    rb0_live[csrm_pkg::RB0_TEST_REF_BIT]   = test_reference_ok;
    rb0_live[csrm_pkg::RB0_SECOND_REF_BIT] = second_reference_ok;
    rb0_live[csrm_pkg::RB0_FIRST_REF_BIT]  = first_reference_ok;
    rb0_live[csrm_pkg::RB0_SYNTH_LOCK_BIT] = synth_loop_locked;
    rb0_live[csrm_pkg::RB0_CLEAN_LOCK_BIT] = cleanup_loop_locked;
    rb1_live[csrm_pkg::RB1_HOLDOVER_BIT]   = holdover_active;
    // auto-chosen reference, meaningless in manual mode
    rb1_live[csrm_pkg::RB1_AUTO_SEL_BIT]   = auto_second_reference;
    rb1_live[csrm_pkg::RB1_CAL_BUSY_BIT]   = osc_cal_busy;
  end

  // ----------------------------------------------------------------
  // Register port next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_sel    = sel_ff;
    nxt_rdata  = rdata_ff;
    nxt_rvalid = reg_rd;
    if (reg_wr && reg_addr == csrm_pkg::MONITOR_PIN_ZERO_SELECT_ADDR) begin
      nxt_sel = reg_wdata[csrm_pkg::SEL_LSB +: csrm_pkg::SEL_W];
    end
    // live read, writes to readback ignored
    if (reg_rd) begin
      case (reg_addr)
        csrm_pkg::CLOCK_PRESENCE_LOCK_STATUS_ADDR: begin
          nxt_rdata = rb0_live;
        end
        csrm_pkg::HOLDOVER_SELECTION_CAL_STATUS_ADDR: begin
          nxt_rdata = rb1_live;
        end
        csrm_pkg::MONITOR_PIN_ZERO_SELECT_ADDR: begin
          nxt_rdata = {2'h0, sel_ff};
        end
        default: begin
          nxt_rdata = '0; // Unmapped reads return zero
        end
      endcase
    end
  end

  // Register port flops
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      sel_ff    <= csrm_pkg::SEL_RESET;
      rdata_ff  <= '0;
      rvalid_ff <= 1'b0;
    end else begin
      sel_ff    <= nxt_sel;
      rdata_ff  <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  // ----------------------------------------------------------------
  // Halved cleanup loop signals
  // ----------------------------------------------------------------
  // Sampling at clk_sys only tracks inputs slower than half its rate
  assign half_src = {cleanup_loop_pfd_up, cleanup_loop_ref_sig,
                     cleanup_loop_pfd_dn, cleanup_loop_fb_sig};

  csrm_halver #(
    .CH       (csrm_pkg::HALF_CH)
  ) u_halver (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .sig_in   (half_src),
    .half_out (half_sig)
  );

  // ----------------------------------------------------------------
  // Monitor pin selection
  // ----------------------------------------------------------------
  assign refs_lost = ~first_reference_ok & ~second_reference_ok;

  always_comb begin
    nxt_pin = 1'b0;
    case (sel_ff)
      csrm_pkg::MON_GND:         nxt_pin = 1'b0;
      csrm_pkg::MON_BOTH_LOCK:
        nxt_pin = cleanup_loop_locked & synth_loop_locked;
      csrm_pkg::MON_CLEAN_LOCK:  nxt_pin = cleanup_loop_locked;
      csrm_pkg::MON_SYNTH_LOCK:  nxt_pin = synth_loop_locked;
      csrm_pkg::MON_REFS_LOST:   nxt_pin = refs_lost;
      csrm_pkg::MON_LOST_SYNTH:  nxt_pin = refs_lost & synth_loop_locked;
      csrm_pkg::MON_AUTO_SECOND: nxt_pin = auto_second_reference;
      csrm_pkg::MON_FIRST_OK:    nxt_pin = first_reference_ok;
      csrm_pkg::MON_SECOND_OK:   nxt_pin = second_reference_ok;
      csrm_pkg::MON_TEST_OK:     nxt_pin = test_reference_ok;
      csrm_pkg::MON_OSC_OK:      nxt_pin = osc_clock_ok;
      csrm_pkg::MON_FB_OK:       nxt_pin = cleanup_loop_fb_ok;
      csrm_pkg::MON_SREF_OK:     nxt_pin = synth_loop_ref_ok;
      csrm_pkg::MON_RSVD:        nxt_pin = 1'b0;
      csrm_pkg::MON_REFS_OK:
        nxt_pin = first_reference_ok & second_reference_ok;
      csrm_pkg::MON_ALL_OK:
        nxt_pin = first_reference_ok & second_reference_ok &
                  osc_clock_ok & cleanup_loop_fb_ok & synth_loop_ref_ok;
      csrm_pkg::MON_FB_HALF:     nxt_pin = half_sig[0];
      csrm_pkg::MON_DN_HALF:     nxt_pin = half_sig[1];
      csrm_pkg::MON_REF_HALF:    nxt_pin = half_sig[2];
      csrm_pkg::MON_UP_HALF:     nxt_pin = half_sig[3];
      // codes 20..23 and reserved codes stay low
      default:                   nxt_pin = 1'b0;
    endcase
  end

  // Pin flop keeps the output glitch-free across selector changes
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      pin_ff <= 1'b0;
    end else begin
      pin_ff <= nxt_pin;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata   = rdata_ff;
  assign reg_rvalid  = rvalid_ff;
  assign monitor_pin = pin_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  synth_ref_bit_a:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      reg_rd && reg_addr == csrm_pkg::CLOCK_PRESENCE_LOCK_STATUS_ADDR
      |=> reg_rdata[7] == $past(synth_loop_ref_ok) && reg_rvalid)
    else $error("synth ref presence bit wrong");

  fb_clock_bit_a:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      reg_rd && reg_addr == csrm_pkg::CLOCK_PRESENCE_LOCK_STATUS_ADDR
      |=> reg_rdata[6] == $past(cleanup_loop_fb_ok))
    else $error("feedback presence bit wrong");

  presence_bits_a:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      reg_rd && reg_addr == csrm_pkg::CLOCK_PRESENCE_LOCK_STATUS_ADDR
      |=> reg_rdata[5:2] == $past({osc_clock_ok, test_reference_ok,
                                   second_reference_ok,
                                   first_reference_ok}))
    else $error("clock presence bits wrong");

  lock_bits_a:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      reg_rd && reg_addr == csrm_pkg::CLOCK_PRESENCE_LOCK_STATUS_ADDR
      |=> reg_rdata[1:0] == $past({synth_loop_locked,
                                   cleanup_loop_locked}))
    else $error("lock bits wrong");

  holdover_bit_a:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      reg_rd && reg_addr == csrm_pkg::HOLDOVER_SELECTION_CAL_STATUS_ADDR
      |=> reg_rdata[3] == $past(holdover_active))
    else $error("holdover bit wrong");

  auto_sel_bit_a:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      reg_rd && reg_addr == csrm_pkg::HOLDOVER_SELECTION_CAL_STATUS_ADDR
      |=> reg_rdata[2] == $past(auto_second_reference))
    else $error("auto selection bit wrong");

  cal_busy_bit_a:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      reg_rd && reg_addr == csrm_pkg::HOLDOVER_SELECTION_CAL_STATUS_ADDR
      |=> reg_rdata[0] == $past(osc_cal_busy) && reg_rdata[7:4] == 4'h0
          && reg_rdata[1] == 1'b0)
    else $error("calibration or reserved bits wrong");

  sel_write_a:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      reg_wr && reg_addr == csrm_pkg::MONITOR_PIN_ZERO_SELECT_ADDR
      |=> sel_ff == $past(reg_wdata[5:0]))
    else $error("selector write wrong");

  pin_lock_a:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      sel_ff == csrm_pkg::MON_BOTH_LOCK
      |=> monitor_pin == $past(cleanup_loop_locked & synth_loop_locked))
    else $error("both-locked pin wrong");

  pin_lost_a:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      sel_ff == csrm_pkg::MON_LOST_SYNTH
      |=> monitor_pin == $past(~first_reference_ok & ~second_reference_ok
                               & synth_loop_locked))
    else $error("lost-with-lock pin wrong");

  pin_auto_a:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      sel_ff == csrm_pkg::MON_AUTO_SECOND
      |=> monitor_pin == $past(auto_second_reference))
    else $error("auto selection pin wrong");

  pin_presence_a:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      sel_ff == csrm_pkg::MON_SREF_OK
      |=> monitor_pin == $past(synth_loop_ref_ok))
    else $error("synth ref pin wrong");

  pin_all_ok_a:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      sel_ff == csrm_pkg::MON_ALL_OK && test_reference_ok == 1'b0
      && first_reference_ok && second_reference_ok && osc_clock_ok
      && cleanup_loop_fb_ok && synth_loop_ref_ok |=> monitor_pin)
    else $error("all-ok pin ignores a clock");

  pin_half_a:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      sel_ff == csrm_pkg::MON_FB_HALF && $stable(sel_ff)
      && $rose(cleanup_loop_fb_sig) |=> ##1 $changed(monitor_pin))
    else $error("halved feedback did not toggle");

  pin_low_a:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      sel_ff > csrm_pkg::MON_UP_HALF |=> !monitor_pin)
    else $error("reserved code drove pin high");

  rb_write_a:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      reg_wr && reg_addr == csrm_pkg::CLOCK_PRESENCE_LOCK_STATUS_ADDR
      |=> $stable(sel_ff))
    else $error("readback write had an effect");

endmodule : csrm_top

// ===== hdl/csrm_pkg.sv
// Purpose: Constants for the clock status readback and monitor block
// Assumes: Register port carries 12-bit addresses and 8-bit data
// Notes:   Selector codes above the last listed one are reserved
package csrm_pkg;

  // ----------------------------------------------------------------
  // Register port geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int SEL_W  = 6;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] CLOCK_PRESENCE_LOCK_STATUS_ADDR    = 12'h22C;
  localparam logic [11:0] HOLDOVER_SELECTION_CAL_STATUS_ADDR = 12'h22D;
  localparam logic [11:0] MONITOR_PIN_ZERO_SELECT_ADDR       = 12'h230;

  // ----------------------------------------------------------------
  // Field positions, first readback register
  // ----------------------------------------------------------------
  localparam int RB0_SYNTH_REF_BIT   = 7;
  localparam int RB0_CLEAN_FB_BIT    = 6;
  localparam int RB0_OSC_BIT         = 5;
  localparam int RB0_TEST_REF_BIT    = 4;
  localparam int RB0_SECOND_REF_BIT  = 3;
  localparam int RB0_FIRST_REF_BIT   = 2;
  localparam int RB0_SYNTH_LOCK_BIT  = 1;
  localparam int RB0_CLEAN_LOCK_BIT  = 0;

  // ----------------------------------------------------------------
  // Field positions, second readback register
  // ----------------------------------------------------------------
  localparam int RB1_HOLDOVER_BIT    = 3;
  localparam int RB1_AUTO_SEL_BIT    = 2;
  localparam int RB1_CAL_BUSY_BIT    = 0;

  // ----------------------------------------------------------------
  // Monitor selector field and codes
  // ----------------------------------------------------------------
  localparam int SEL_LSB = 0;
  localparam logic [5:0] SEL_RESET        = 6'h00;
  localparam logic [5:0] MON_GND          = 6'h00;
  localparam logic [5:0] MON_BOTH_LOCK    = 6'h01;
  localparam logic [5:0] MON_CLEAN_LOCK   = 6'h02;
  localparam logic [5:0] MON_SYNTH_LOCK   = 6'h03;
  localparam logic [5:0] MON_REFS_LOST    = 6'h04;
  localparam logic [5:0] MON_LOST_SYNTH   = 6'h05;
  localparam logic [5:0] MON_AUTO_SECOND  = 6'h06;
  localparam logic [5:0] MON_FIRST_OK     = 6'h07;
  localparam logic [5:0] MON_SECOND_OK    = 6'h08;
  localparam logic [5:0] MON_TEST_OK      = 6'h09;
  localparam logic [5:0] MON_OSC_OK       = 6'h0A;
  localparam logic [5:0] MON_FB_OK        = 6'h0B;
  localparam logic [5:0] MON_SREF_OK      = 6'h0C;
  localparam logic [5:0] MON_RSVD         = 6'h0D;
  localparam logic [5:0] MON_REFS_OK      = 6'h0E;
  localparam logic [5:0] MON_ALL_OK       = 6'h0F;
  localparam logic [5:0] MON_FB_HALF      = 6'h10;
  localparam logic [5:0] MON_DN_HALF      = 6'h11;
  localparam logic [5:0] MON_REF_HALF     = 6'h12;
  localparam logic [5:0] MON_UP_HALF      = 6'h13;
  localparam logic [5:0] MON_LAST_CODE    = 6'h17;

  // Halved channel order: feedback, down, reference, up
  localparam int HALF_CH = 4;

endpackage : csrm_pkg

// ===== hdl/csrm_halver.sv
// Purpose: Divide-by-2 of sampled loop signals for the monitor pin
// Assumes: Inputs are synchronous to clk_sys and change slower than it
// Notes:   Each output toggles on every rising edge of its input
module csrm_halver #(
  parameter int CH = 4
) (
  // Clock and reset
  input  wire logic          clk_sys,
  input  wire logic          nrst,
  // Signals to halve
  input  wire logic [CH-1:0] sig_in,
  // Halved signals
  output logic      [CH-1:0] half_out
);

  // ----------------------------------------------------------------
  // One toggle stage per channel
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < CH; g++) begin : g_ch
      logic prev_ff;
      logic tog_ff;
      logic nxt_prev;
      logic nxt_tog;

      // Toggle on rising edge, so output runs at half the input rate
      always_comb begin
        nxt_prev = sig_in[g];
        nxt_tog  = tog_ff ^ (sig_in[g] & ~prev_ff);
      end

      // Registers only
      always_ff @(posedge clk_sys) begin
        if (!nrst) begin
          prev_ff <= 1'b0;
          tog_ff  <= 1'b0;
        end else begin
          prev_ff <= nxt_prev;
          tog_ff  <= nxt_tog;
        end
      end

      assign half_out[g] = tog_ff;
    end
  endgenerate

endmodule : csrm_halver

// ===== tb/csrm_board_monitor.sv
// Purpose: Board logic that watches the status monitor pin
// Assumes: Pin is sampled on clk_sys by the board
// Notes:   Counts level changes so halved sources can be judged
module csrm_board_monitor (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic nrst,
  // Pin under watch
  input  wire logic monitor_pin,
  // Observed level changes
  output int        toggle_count
);
  timeunit 1ns;
  timeprecision 1ns;

  logic last_pin;

  // halved rate seen
  // Every sampled change counts; a halved source gives one per input rise
  always @(posedge clk_sys) begin
    if (!nrst) begin
      toggle_count <= 0;
      last_pin     <= 1'b0;
    end else begin
      if (monitor_pin !== last_pin) begin
        toggle_count <= toggle_count + 1;
      end
      last_pin <= monitor_pin;
    end
  end
endmodule : csrm_board_monitor

// ===== tb/clock_status_readback_monitor_bench.sv
// Purpose: Self-checking bench for the status readback and monitor block
// Assumes: Register port answers reads one cycle after the strobe
// Notes:   Status bits travel packed in stat, readback zero order at [7:0]
module clock_status_readback_monitor_bench;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {
    logic [5:0]  code;
    logic [10:0] stat;
    logic        exp;
  } csrm_row_s;

  logic        clk_sys, nrst, reg_wr, reg_rd, monitor_pin, reg_rvalid;
  logic [11:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, rdat;
  logic [10:0] stat;
  logic [3:0]  half_sig;
  int          n_mismatch, samples_checked, cycles, toggle_count, c0;

  // --------------------------------------------------------------
  // Rows: selector code, status {cal,auto,hold,rb0[7:0]}, pin level
  // --------------------------------------------------------------
  csrm_row_s rows [28] = '{
    '{6'h00, 11'h7FF, 1'b0}, '{6'h01, 11'h003, 1'b1}, '{6'h01, 11'h002, 1'b0},
    '{6'h02, 11'h001, 1'b1}, '{6'h02, 11'h7FE, 1'b0}, '{6'h03, 11'h002, 1'b1},
    '{6'h03, 11'h7FD, 1'b0}, '{6'h04, 11'h000, 1'b1}, '{6'h04, 11'h004, 1'b0},
    '{6'h05, 11'h002, 1'b1}, '{6'h05, 11'h000, 1'b0}, '{6'h06, 11'h200, 1'b1},
    '{6'h06, 11'h5FF, 1'b0}, '{6'h07, 11'h004, 1'b1}, '{6'h08, 11'h008, 1'b1},
    '{6'h08, 11'h7F7, 1'b0}, '{6'h09, 11'h010, 1'b1}, '{6'h0A, 11'h020, 1'b1},
    '{6'h0B, 11'h040, 1'b1}, '{6'h0C, 11'h080, 1'b1}, '{6'h0D, 11'h7FF, 1'b0},
    '{6'h0E, 11'h00C, 1'b1}, '{6'h0E, 11'h008, 1'b0}, '{6'h0F, 11'h0EC, 1'b1},
    '{6'h0F, 11'h0DC, 1'b0}, '{6'h14, 11'h7FF, 1'b0}, '{6'h15, 11'h7FF, 1'b0},
    '{6'h17, 11'h7FF, 1'b0}};

  csrm_top uut (
    .clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .first_reference_ok(stat[2]),
    .second_reference_ok(stat[3]), .test_reference_ok(stat[4]),
    .osc_clock_ok(stat[5]), .cleanup_loop_fb_ok(stat[6]),
    .synth_loop_ref_ok(stat[7]), .cleanup_loop_locked(stat[0]),
    .synth_loop_locked(stat[1]), .holdover_active(stat[8]),
    .auto_second_reference(stat[9]), .osc_cal_busy(stat[10]),
    .cleanup_loop_fb_sig(half_sig[0]), .cleanup_loop_pfd_dn(half_sig[1]),
    .cleanup_loop_ref_sig(half_sig[2]), .cleanup_loop_pfd_up(half_sig[3]),
    .monitor_pin(monitor_pin));

  csrm_board_monitor board (
    .clk_sys(clk_sys), .nrst(nrst), .monitor_pin(monitor_pin),
    .toggle_count(toggle_count));

  // --------------------------------------------------------------
  // Clock, timeout and shared tasks
  // --------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Ceiling well above the few hundred cycles the tests need
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string what, input logic [7:0] e,
                     input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(posedge clk_sys);
    #1;
    reg_wr = 1'b0;
  endtask : wr

  // Read answers at the edge after the strobe; rvalid checked there
  task automatic rd(input string what, input logic [11:0] a,
                    input logic [7:0] e);
    @(posedge clk_sys);
    #1;
    reg_rd   = 1'b1;
    reg_addr = a;
    @(posedge clk_sys);
    #1;
    reg_rd = 1'b0;
    chk("rvalid", 8'h01, {7'h00, reg_rvalid});
    chk(what, e, reg_rdata);
  endtask : rd

  task automatic pin_chk(input logic e);
    chk("monitor_pin", {7'h00, e}, {7'h00, monitor_pin});
  endtask : pin_chk

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    nrst = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 12'h000;
    reg_wdata = 8'h00; stat = 11'h000; half_sig = 4'h0;
    repeat (3) @(posedge clk_sys);
    #1;
    nrst = 1'b1;
    pin_chk(1'b0);
    chk("rvalid_idle", 8'h00, {7'h00, reg_rvalid});
    rd("sel_reset", 12'h230, 8'h00);
    $display("TEST reset done");

    // Reserved selector bits written high must read back low
    for (int i = 0; i < 28; i++) begin
      wr(12'h230, {2'b11, rows[i].code});
      stat = rows[i].stat;
      repeat (3) @(posedge clk_sys);
      #1;
      pin_chk(rows[i].exp);
      rd("sel", 12'h230, {2'b00, rows[i].code});
      rd("rb0", 12'h22C, stat[7:0]);
      rdat = {4'h0, stat[8], stat[9], 1'b0, stat[10]};
      rd("rb1", 12'h22D, rdat);
    end
    $display("TEST rows done");

    // Top code with all bits set, write attempts on readbacks, unmapped
    stat = 11'h7FF;
    wr(12'h230, 8'hFF);
    repeat (3) @(posedge clk_sys);
    #1;
    pin_chk(1'b0);
    rd("sel_max", 12'h230, 8'h3F);
    wr(12'h22C, 8'h00);
    wr(12'h22D, 8'hFF);
    rd("rb0_ro", 12'h22C, 8'hFF);
    rd("rb1_ro", 12'h22D, 8'h0D);
    rd("unmapped", 12'h231, 8'h00);
    $display("TEST access done");

    // Halved sources: three input rises give three pin changes
    for (int k = 0; k < 4; k++) begin
      wr(12'h230, 8'h10 + 8'(k));
      repeat (3) @(posedge clk_sys);
      #1;
      pin_chk(1'b0);
      c0 = toggle_count;
      repeat (3) begin
        half_sig[k] = 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        half_sig[k] = 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
      end
      repeat (3) @(posedge clk_sys);
      #1;
      pin_chk(1'b1);
      chk("toggles", 8'h03, 8'(toggle_count - c0));
    end
    $display("TEST halved done");

    // Reset in mid-run returns the selector to ground
    wr(12'h230, 8'h01);
    stat = 11'h003;
    repeat (2) @(posedge clk_sys);
    #1;
    pin_chk(1'b1);
    nrst = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    nrst = 1'b1;
    pin_chk(1'b0);
    rd("sel_rerst", 12'h230, 8'h00);
    $display("TEST rerun reset done");
    end_of_test();
  end
endmodule : clock_status_readback_monitor_bench
